// File: qenc_pkg.sv
// constants shared by the encoder counter and its input filter
// assumes a 100 MHz system clock and a 32-bit AXI4-Lite register port
package qenc_pkg;

  // system clock and input sample rates, in hertz
  localparam logic [27:0] SYS_CLK_HZ       = 28'h5f5e100;
  localparam logic [27:0] SAMPLE_HZ_BUS    = 28'h1f78a40;
  localparam logic [27:0] SAMPLE_HZ_PORT   = 28'h2faf080;

  // samples a change must persist before it is accepted
  localparam logic [3:0]  PERSIST_FILTERED = 4'hf;
  localparam logic [3:0]  PERSIST_FAST     = 4'h3;

  // register byte offsets
  localparam logic [7:0]  CTRL_OFS         = 8'h00;
  localparam logic [7:0]  STATUS_OFS       = 8'h04;
  localparam logic [7:0]  MASK_OFS         = 8'h08;
  localparam logic [7:0]  COUNT_OFS        = 8'h0c;
  localparam logic [7:0]  RAW_OFS          = 8'h10;
  localparam logic [7:0]  INPUTS_OFS       = 8'h14;

  // control field positions
  localparam int          CTRL_W           = 7;
  localparam int          CTRL_MODE_BIT    = 0;
  localparam int          CTRL_FILTER_BIT  = 1;
  localparam int          CTRL_RISE_BIT    = 2;
  localparam int          CTRL_GATE_EN_BIT = 3;
  localparam int          CTRL_GATE_INV_BIT = 4;
  localparam int          CTRL_ARM_BIT     = 5;
  localparam int          CTRL_CLEAR_BIT   = 6;
  localparam logic [6:0]  CTRL_RESET       = 7'h02;

  // status and mask field positions
  localparam int          STAT_W           = 2;
  localparam int          STAT_INDEX_BIT   = 0;
  localparam int          STAT_ERR_BIT     = 1;
  localparam logic [1:0]  STAT_RESET       = 2'h0;
  localparam logic [1:0]  MASK_RESET       = 2'h0;

  // count reset value and step sizes
  localparam logic [31:0] COUNT_RESET      = 32'h00000000;
  localparam logic [31:0] STEP_UP          = 32'h00000001;
  localparam logic [31:0] STEP_DOWN        = 32'hffffffff;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage : qenc_pkg

// File: input_filter.sv
// one encoder input: two-stage synchroniser, then a persistence filter
// assumes sample_tick is a one-cycle strobe from the aclk domain
`timescale 1ns/1ns
module input_filter (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // raw pin and sampling control
  input  wire logic       raw_in,
  input  wire logic       sample_tick,
  input  wire logic [3:0] persist,
  // filtered level
  output logic            filt_out
);
  import qenc_pkg::*;

  logic       sync1_r;
  logic       sync2_r;
  logic       filt_r;
  logic [3:0] cnt_r;

  wire        differs  = sync2_r != filt_r;
  wire        last_smp = cnt_r == (persist - 4'h1);

  // sync1_r feeds only sync2_r so a metastable level never reaches logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= raw_in;  // see (R15)
      sync2_r <= sync1_r; // see (R15)
    end
  end

  // a change is taken only after persist consecutive differing samples
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_r <= 1'b0;
      cnt_r  <= 4'h0;
    end else if (sample_tick) begin
      if (!differs) begin
        cnt_r  <= 4'h0;            // see (R3) (R4)
      end else if (last_smp) begin
        filt_r <= sync2_r;         // see (R3) (R4)
        cnt_r  <= 4'h0;
      end else begin
        cnt_r  <= cnt_r + 4'h1;
      end
    end
  end

  assign filt_out = filt_r;

endmodule : input_filter

// File: quadrature_encoder_counter.sv
// incremental encoder counter with index zeroing, raw tally and AXI4-Lite registers
// assumes encoder pins are asynchronous and the bus master runs on aclk
//
// What this block does
// (R1) default mode counts every A and B edge, four per line, direction from phase
// (R2) mode bit set: count once per A rising edge, B gives direction
// (R3) filter on (reset default): input change must persist 15 samples
// (R4) filter off: input change accepted after 3 stable samples
// (R5) sample rate is 33 MHz on bus cards, 50 MHz on port variant
// (R6) armed index event zeroes count and clears the arm flag
// (R7) edge select picks rising index edge when set, falling when clear
// (R8) with gating enabled, index acts only at active gate level
// (R9) gate invert set means gate must be low, clear means high
// (R10) clear input holds count at zero while asserted
// (R11) clear is level sensitive; software must release it itself
// (R12) separate raw total ignores index zeroing and clear
// (R13) main count is signed 32 bits since last clear or index
// (R14) three inputs, or four with gate, chosen at build time
// (R15) every encoder input is synchronised by two flip-flops first
// (R16) A leading B counts up, B leading counts down, double steps ignored
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
module quadrature_encoder_counter #(
  parameter bit BUILD_GATE   = 1'b1,
  parameter bit PORT_VARIANT = 1'b0
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // encoder pins
  input  wire logic        enc_a,
  input  wire logic        enc_b,
  input  wire logic        enc_index,
  input  wire logic        enc_gate,
  // write address channel
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // write response channel
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // read address channel
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // read data channel
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // interrupt
  output logic             irq
);
  import qenc_pkg::*;

  localparam int NUM_IN = BUILD_GATE ? 4 : 3;

  // sample strobe from a phase accumulator; 100/33 is not an integer ratio
  logic [27:0] acc_r;
  logic [27:0] acc_nxt;
  wire  [27:0] sample_rate = PORT_VARIANT ? SAMPLE_HZ_PORT : SAMPLE_HZ_BUS; // see (R5)
  wire  [27:0] acc_sum     = acc_r + sample_rate;
  wire         sample_tick = acc_sum >= SYS_CLK_HZ;                        // see (R5)

  assign acc_nxt = sample_tick ? (acc_sum - SYS_CLK_HZ) : acc_sum;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= 28'h0000000;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // control, status and mask registers
  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [STAT_W-1:0] stat_r;
  logic [STAT_W-1:0] stat_nxt;
  logic [STAT_W-1:0] mask_r;
  logic [STAT_W-1:0] mask_nxt;

  wire mode_updown = ctrl_r[CTRL_MODE_BIT];
  wire filter_on   = ctrl_r[CTRL_FILTER_BIT];
  wire idx_rise    = ctrl_r[CTRL_RISE_BIT];
  wire gate_en     = ctrl_r[CTRL_GATE_EN_BIT];
  wire gate_inv    = ctrl_r[CTRL_GATE_INV_BIT];
  wire armed       = ctrl_r[CTRL_ARM_BIT];
  wire clear_lvl   = ctrl_r[CTRL_CLEAR_BIT];

  // input filters, one per pin present in this build
  wire [3:0] raw_vec = {enc_gate, enc_index, enc_b, enc_a};
  wire [3:0] persist = filter_on ? PERSIST_FILTERED : PERSIST_FAST; // see (R3) (R4)
  logic [3:0] filt_vec;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_in // see (R14)
      input_filter u_filt (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .raw_in      (raw_vec[gi]),
        .sample_tick (sample_tick),
        .persist     (persist),
        .filt_out    (filt_vec[gi])
      );
    end
    if (!BUILD_GATE) begin : g_nogate
      assign filt_vec[3] = 1'b0; // see (R14)
    end
  endgenerate

  wire fa = filt_vec[0];
  wire fb = filt_vec[1];
  wire fi = filt_vec[2];
  wire fg = filt_vec[3];

  // previous filtered levels
  logic pa_r;
  logic pb_r;
  logic pi_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pa_r <= 1'b0;
      pb_r <= 1'b0;
      pi_r <= 1'b0;
    end else begin
      pa_r <= fa;
      pb_r <= fb;
      pi_r <= fi;
    end
  end

  // quadrature decode: one phase moving is a step, both at once is an error
  wire da       = fa ^ pa_r;
  wire db       = fb ^ pb_r;
  wire quad_stp = da ^ db;            // see (R1)
  wire quad_up  = ~(pa_r ^ fb);       // see (R16)
  wire quad_err = da & db;            // see (R16)

  // up/down mode: A rising edge steps, B high counts up
  wire ud_stp   = fa & ~pa_r;         // see (R2)
  wire ud_up    = fb;                 // see (R2)

  wire step     = mode_updown ? ud_stp : quad_stp;
  wire step_up  = mode_updown ? ud_up : quad_up;
  wire [31:0] delta = step ? (step_up ? STEP_UP : STEP_DOWN) : COUNT_RESET;
  wire err_evt  = quad_err & ~mode_updown;

  // index qualification
  wire idx_edge   = idx_rise ? (fi & ~pi_r) : (~fi & pi_r); // see (R7)
  wire gate_lvl   = fg ^ gate_inv;                          // see (R9)
  wire gate_ok    = !BUILD_GATE || !gate_en || gate_lvl;    // see (R8)
  wire idx_evt    = idx_edge & gate_ok;
  wire index_fire = idx_evt & armed;                        // see (R6)

  // counters
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic [31:0] raw_r;
  logic [31:0] raw_nxt;

  // clear dominates: the count stays zero for as long as software holds it
  assign count_nxt = clear_lvl  ? COUNT_RESET :   // see (R10) (R11)
                     index_fire ? COUNT_RESET :   // see (R6)
                     count_r + delta;             // see (R13)
  assign raw_nxt   = raw_r + delta;               // see (R12)

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= COUNT_RESET;
    end else begin
      count_r <= count_nxt;
    end
  end

  // raw total has its own register so no clear path can ever reach it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_r <= COUNT_RESET;
    end else begin
      raw_r <= raw_nxt; // see (R12)
    end
  end

  // AXI write path: address and data are held until both are present
  logic        aw_held_r;
  logic [7:0]  awaddr_r;
  logic        w_held_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_held_r & w_held_r;

  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;

  wire wr_ctrl   = wr_fire & (awaddr_r == CTRL_OFS) & wstrb_r[0];
  wire wr_stat   = wr_fire & (awaddr_r == STATUS_OFS) & wstrb_r[0];
  wire wr_mask   = wr_fire & (awaddr_r == MASK_OFS) & wstrb_r[0];
  wire wr_mapped = (awaddr_r == CTRL_OFS) | (awaddr_r == STATUS_OFS) |
                   (awaddr_r == MASK_OFS) | (awaddr_r == COUNT_OFS) |
                   (awaddr_r == RAW_OFS) | (awaddr_r == INPUTS_OFS);

  // address half; a take and the fire never share a cycle since awready needs !aw_held_r
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r  <= 8'h00;
    end else if (aw_take) begin
      aw_held_r <= 1'b1;
      awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  // data half, held the same way
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r  <= 32'h00000000;
      wstrb_r  <= 4'h0;
    end else if (w_take) begin
      w_held_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  // response: costs one cycle but keeps the register write off the bus inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // a software write of the control word wins over the hardware disarm
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (index_fire) begin
      ctrl_nxt[CTRL_ARM_BIT] = 1'b0; // see (R6)
    end
    if (wr_ctrl) begin
      ctrl_nxt = wdata_r[CTRL_W-1:0];
    end
  end

  // sticky events: a new event in the clearing cycle survives
  wire [STAT_W-1:0] stat_evt = {err_evt, index_fire};
  wire [STAT_W-1:0] stat_clr = wr_stat ? wdata_r[STAT_W-1:0] : {STAT_W{1'b0}};

  assign stat_nxt = (stat_r & ~stat_clr) | stat_evt;
  assign mask_nxt = wr_mask ? wdata_r[STAT_W-1:0] : mask_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RESET; // see (R3)
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_r <= STAT_RESET;
    end else begin
      stat_r <= stat_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= MASK_RESET;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  assign irq = |(stat_r & mask_r);

  // AXI read path: one read at a time, data registered
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  logic [31:0] rd_mux;
  logic        rd_hit;

  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
  wire       ar_take = s_axi_arvalid & s_axi_arready;

  assign s_axi_arready = ~rvalid_r;

  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (rd_addr)
      CTRL_OFS:   rd_mux[CTRL_W-1:0] = ctrl_r;
      STATUS_OFS: rd_mux[STAT_W-1:0] = stat_r;
      MASK_OFS:   rd_mux[STAT_W-1:0] = mask_r;
      COUNT_OFS:  rd_mux = count_r;
      RAW_OFS:    rd_mux = raw_r;
      INPUTS_OFS: rd_mux[3:0] = filt_vec;
      default:    rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

endmodule : quadrature_encoder_counter

// File: quadrature_encoder_counter_asserts.sv
// bus handshake and interrupt checks for the encoder counter
// assumes it is bound to the counter, ports matched by name
`timescale 1ns/1ns
module quadrature_encoder_counter_asserts
  import qenc_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // interrupt
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  AST_READ_STAND: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read moved");
  AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while busy");
  AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  AST_B_STAND: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("response moved");
  AST_SLVERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |->
    s_axi_rdata == 32'h0) else $error("error read data");
  AST_IRQ_STICKY: assert property ($fell(irq) |-> s_axi_bvalid)
    else $error("irq fell without a write");
endmodule : quadrature_encoder_counter_asserts

bind quadrature_encoder_counter quadrature_encoder_counter_asserts chk (.*);

// File: encoder_model.sv
// encoder stand-in: quadrature pins plus index and gate, moved by tasks
// assumes callers run in step with aclk; pins are push-pull, never released
`timescale 1ns/1ns
module encoder_model (
  // clock
  input wire logic aclk,
  // encoder pins
  output logic     enc_a,
  output logic     enc_b,
  output logic     enc_index,
  output logic     enc_gate
);
  initial {enc_gate, enc_index, enc_b, enc_a} = 4'h0;
  // set all pins at once and hold them, so the filter sees clean levels
  task automatic pins(input logic [3:0] v, input int hold);
    @(posedge aclk);
    {enc_gate, enc_index, enc_b, enc_a} <= v;
    repeat (hold) @(posedge aclk);
  endtask : pins
  // one edge: a leads b going up, b leads a going down
  task automatic step(input bit up, input int hold);
    pins({enc_gate, enc_index, enc_b ^ ((enc_a == enc_b) != up),
          enc_a ^ ((enc_a == enc_b) == up)}, hold);
  endtask : step
endmodule : encoder_model

// File: test_quadrature_encoder_counter.sv
// self-checking bench: counting table, then clear, double steps, index, bus errors
// assumes the encoder model drives the pins and the checker is bound
`timescale 1ns/1ns
module test_quadrature_encoder_counter;
  import qenc_pkg::*;
  typedef struct {
    logic [31:0] ctrl;
    int          n;
    bit          up;
    int          hold;
    logic [31:0] cnt;
  } row_s;
  logic        aclk, aresetn, enc_a, enc_b, enc_index, enc_gate, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, raw_exp, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          bad_count, comparisons;
  // quadrature rows bring the pins back to where they started
  row_s        rows [6] = '{'{32'h02, 4, 1, 64, 32'h4}, '{32'h02, 4, 0, 64, 32'hfffffffc},
    '{32'h00, 8, 1, 15, 32'h8}, '{32'h02, 4, 1, 15, 32'h0},
    '{32'h03, 3, 1, 64, 32'h3}, '{32'h03, 2, 0, 64, 32'hfffffffe}};
  logic [31:0] ix_ctrl [7] = '{32'h26, 32'h26, 32'h2e, 32'h2a, 32'h3e, 32'h3a, 32'h26};
  logic [6:0]  ix_gate = 7'b0011000;
  logic [6:0]  ix_fire = 7'b1101001;
  logic [7:0]  rst_ofs [4] = '{STATUS_OFS, MASK_OFS, COUNT_OFS, RAW_OFS};

  quadrature_encoder_counter dut (.*);
  encoder_model m (.*);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // bready rises only once bvalid is seen, so the slave is stalled a cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      s_axi_bready <= s_axi_bvalid;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      s_axi_rready <= s_axi_rvalid;
    end
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  task automatic wrok(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] resp;
    wr(a, v, resp);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
  endtask : wrok

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0]  resp;
    rd(a, v, resp);
    chk({30'h0, resp}, {30'h0, RESP_OKAY});
    chk(v, exp);
  endtask : rdchk

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    raw_exp = 32'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(CTRL_OFS, {25'h0, CTRL_RESET});
    foreach (rst_ofs[i]) rdchk(rst_ofs[i], 32'h0);
    $display("reset values done");
    wrok(MASK_OFS, 32'h1);
    foreach (rows[i]) begin
      wrok(CTRL_OFS, rows[i].ctrl | 32'h40);
      rdchk(COUNT_OFS, 32'h0);
      wrok(CTRL_OFS, rows[i].ctrl);
      repeat (rows[i].n) begin
        if (rows[i].ctrl[CTRL_MODE_BIT]) begin
          m.pins({enc_gate, enc_index, rows[i].up, 1'b0}, rows[i].hold);
          m.pins({enc_gate, enc_index, rows[i].up, 1'b1}, rows[i].hold);
        end else begin
          m.step(rows[i].up, rows[i].hold);
        end
      end
      rdchk(COUNT_OFS, rows[i].cnt);
      raw_exp += rows[i].cnt;
      $display("row %0d done", i);
    end
    // clear holds the count at zero even while the shaft moves
    wrok(CTRL_OFS, 32'h42);
    m.step(1'b1, 64);
    rdchk(COUNT_OFS, 32'h0);
    wrok(CTRL_OFS, 32'h02);
    m.step(1'b1, 64);
    rdchk(COUNT_OFS, 32'h1);
    m.pins({enc_gate, enc_index, ~enc_b, ~enc_a}, 64);
    rdchk(COUNT_OFS, 32'h1);
    rdchk(STATUS_OFS, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wrok(STATUS_OFS, 32'h2);
    raw_exp += 2;
    $display("clear and double step done");
    foreach (ix_ctrl[i]) begin
      wrok(CTRL_OFS, 32'h42);
      wrok(CTRL_OFS, 32'h02);
      m.step(1'b1, 64);
      m.step(1'b1, 64);
      m.pins({ix_gate[i], enc_index, enc_b, enc_a}, 64);
      wrok(CTRL_OFS, ix_ctrl[i]);
      m.pins({ix_gate[i], ~enc_index, enc_b, enc_a}, 64);
      rdchk(COUNT_OFS, ix_fire[i] ? 32'h0 : 32'h2);
      rdchk(CTRL_OFS, ix_fire[i] ? ix_ctrl[i] & ~32'h20 : ix_ctrl[i]);
      chk({31'h0, irq}, {31'h0, ix_fire[i]});
      wrok(STATUS_OFS, 32'h1);
      chk({31'h0, irq}, 32'h0);
      raw_exp += 2;
      $display("index case %0d done", i);
    end
    wr(8'h18, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rd(8'h1c, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    chk(d, 32'h0);
    wrok(COUNT_OFS, 32'h5);
    rdchk(COUNT_OFS, 32'h0);
    rdchk(RAW_OFS, raw_exp);
    rdchk(INPUTS_OFS, {28'h0, enc_gate, enc_index, enc_b, enc_a});
    // a write with byte lane 0 off must leave the control word alone
    s_axi_wstrb <= 4'h0;
    wrok(CTRL_OFS, 32'h43);
    s_axi_wstrb <= 4'hf;
    rdchk(CTRL_OFS, 32'h06);
    $display("bus errors and raw total done");
    results();
  end
endmodule : test_quadrature_encoder_counter
